// ### common/rtcca_params.svh
`ifndef RTCCA_PARAMS_SVH
`define RTCCA_PARAMS_SVH
// register byte offsets
`define RTCCA_OFS_CFG 12'h000
`define RTCCA_OFS_PAD 12'h004
`define RTCCA_OFS_ALCFG 12'h008
`define RTCCA_OFS_VAL 12'h00C
`define RTCCA_OFS_ALM 12'h010
`define RTCCA_OFS_KEY 12'h014
// clock_config_and_trim field positions
`define RTCCA_B_EN 15
`define RTCCA_B_UNLOCK 13
`define RTCCA_B_OE 10
// pad_output_config field position
`define RTCCA_B_PINSEL 1
// unlock key sequence
`define RTCCA_KEY1 8'h55
`define RTCCA_KEY2 8'hAA
// timing: crystal pulses per second, carry window before rollover
`define RTCCA_XTAL_HZ 32768
`define RTCCA_SYNC_WIN 17'h0020
// time reset value: 2000-01-01 00:00:00
`define RTCCA_DAY_RST 8'h01
`define RTCCA_MON_RST 8'h01
// stored value masks
`define RTCCA_M_SEC 8'h7F
`define RTCCA_M_HR 8'h3F
`define RTCCA_M_WD 8'h07
`define RTCCA_M_MON 8'h1F
`endif

// ### common/rtcca_pkg.sv
`default_nettype none
package rtcca_pkg;
  typedef enum logic [1:0] {
    RTCCA_IDLE = 2'b00,
    RTCCA_ACC = 2'b01,
    RTCCA_DONE = 2'b11
  } rtcca_apb_t;
  typedef enum logic [1:0] {
    RTCCA_KEY_NONE = 2'b00,
    RTCCA_KEY_55 = 2'b01,
    RTCCA_KEY_OK = 2'b11
  } rtcca_key_t;
  typedef struct packed {
    logic en;
    logic unlock;
    logic oe;
    logic [1:0] ptr;
    logic [7:0] cal;
  } rtcca_cfg_t;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] wday;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] yr;
  } rtcca_time_t;
  typedef struct packed {
    rtcca_apb_t apb;
    rtcca_key_t key;
    rtcca_cfg_t cfg;
    logic pin_sel;
    logic armed;
    logic chime;
    logic [3:0] ival;
    logic [1:0] aptr;
    logic [7:0] rpt;
    rtcca_time_t tm;
    rtcca_time_t al;
    logic [16:0] cnt;
    logic [2:0] xs;
    logic chk;
    logic half_chk;
    logic evt;
    logic pin;
    logic pin_oe_b;
    logic [31:0] rdata;
    logic slverr;
  } rtcca_st_t;
endpackage
`default_nettype wire

// ### hw/rtcca_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcca_params.svh"
module rtcca_top
  import rtcca_pkg::*;
#(
  parameter int unsigned XTAL_HZ = `RTCCA_XTAL_HZ
) (
  input wire logic i_clk, // 100 MHz system clock
  input wire logic i_rst_b, // system reset, sync, active low
  input wire logic i_por_b, // power-on reset, sync, active low
  input wire logic i_xtal, // 32.768 kHz crystal clock, async
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb byte strobes
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped address
  output logic o_rtc_pin, // clock output pin value
  output logic o_rtc_pin_oe_b, // pin enable, low while driving
  output logic o_alarm_evt // one-cycle alarm event
);
  localparam logic [16:0] LAST = 17'(XTAL_HZ - 1);
  localparam logic [16:0] HALF = 17'(XTAL_HZ / 2);

  rtcca_st_t s_q, s_d;

  // =========================================================
  // bcd helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: last_day = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  // =========================================================
  // timebase status
  logic rise, half_now, sync_now, sec_tick, half_tick, min_roll;
  logic [16:0] cal_off;
  always_comb begin
    rise = s_q.xs[1] & ~s_q.xs[2];
    half_now = $signed(s_q.cnt) >= $signed(HALF);
    sync_now = s_q.cfg.en & ($signed(s_q.cnt) >= $signed(LAST - `RTCCA_SYNC_WIN));
    sec_tick = s_q.cfg.en & rise & (s_q.cnt == LAST);
    half_tick = s_q.cfg.en & rise & (s_q.cnt == HALF - 17'h00001);
    min_roll = sec_tick & (s_q.tm.sec == 8'h59);
    cal_off = {{7{s_q.cfg.cal[7]}}, s_q.cfg.cal, 2'b00};
  end

  // =========================================================
  // alarm compare
  logic m_s1, m_s, m_m1, m_m, m_h, m_w, m_d, m_mo, hit;
  always_comb begin
    m_s1 = s_q.tm.sec[3:0] == s_q.al.sec[3:0];
    m_s = s_q.tm.sec == s_q.al.sec;
    m_m1 = m_s & (s_q.tm.min[3:0] == s_q.al.min[3:0]);
    m_m = m_s & (s_q.tm.min == s_q.al.min);
    m_h = m_m & (s_q.tm.hr == s_q.al.hr);
    m_w = m_h & (s_q.tm.wday == s_q.al.wday);
    m_d = m_h & (s_q.tm.day == s_q.al.day);
    m_mo = m_d & (s_q.tm.mon == s_q.al.mon);
    case (s_q.ival)
      4'h0: hit = s_q.chk | s_q.half_chk;
      4'h1: hit = s_q.chk;
      4'h2: hit = s_q.chk & m_s1;
      4'h3: hit = s_q.chk & m_s;
      4'h4: hit = s_q.chk & m_m1;
      4'h5: hit = s_q.chk & m_m;
      4'h6: hit = s_q.chk & m_h;
      4'h7: hit = s_q.chk & m_w;
      4'h8: hit = s_q.chk & m_d;
      4'h9: hit = s_q.chk & m_mo;
      default: hit = 1'b0;
    endcase
  end

  // =========================================================
  // apb decode
  logic done, wr, rd_eff, a_cfg, a_pad, a_alc, a_val, a_alm, a_key, mapped;
  logic [15:0] val_rd, alm_rd;
  always_comb begin
    done = (s_q.apb == RTCCA_DONE) & i_psel & i_penable;
    wr = done & i_pwrite;
    a_cfg = i_paddr == `RTCCA_OFS_CFG;
    a_pad = i_paddr == `RTCCA_OFS_PAD;
    a_alc = i_paddr == `RTCCA_OFS_ALCFG;
    a_val = i_paddr == `RTCCA_OFS_VAL;
    a_alm = i_paddr == `RTCCA_OFS_ALM;
    a_key = i_paddr == `RTCCA_OFS_KEY;
    mapped = a_cfg | a_pad | a_alc | a_val | a_alm | a_key;
    // a read of either byte moves the pointer, a write only via the high byte
    rd_eff = ~i_pwrite | i_pstrb[1];
    case (s_q.cfg.ptr)
      2'b00: val_rd = {s_q.tm.min, s_q.tm.sec};
      2'b01: val_rd = {s_q.tm.wday, s_q.tm.hr};
      2'b10: val_rd = {s_q.tm.mon, s_q.tm.day};
      default: val_rd = {8'h00, s_q.tm.yr};
    endcase
    case (s_q.aptr)
      2'b00: alm_rd = {s_q.al.min, s_q.al.sec};
      2'b01: alm_rd = {s_q.al.wday, s_q.al.hr};
      2'b10: alm_rd = {s_q.al.mon, s_q.al.day};
      default: alm_rd = 16'h0000;
    endcase
  end

  // =========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.xs = {s_q.xs[1:0], i_xtal};
    s_d.chk = sec_tick;
    s_d.half_chk = half_tick;
    // time advance
    if (s_q.cfg.en && rise) begin
      if (s_q.cnt == LAST) begin
        // trim lands once a minute by shortening or stretching the next second
        s_d.cnt = min_roll ? cal_off : 17'h00000;
      end else begin
        s_d.cnt = s_q.cnt + 17'h00001;
      end
    end
    if (sec_tick) begin
      s_d.tm.sec = (s_q.tm.sec == 8'h59) ? 8'h00 : bcd_inc(s_q.tm.sec);
      if (s_q.tm.sec == 8'h59) begin
        s_d.tm.min = (s_q.tm.min == 8'h59) ? 8'h00 : bcd_inc(s_q.tm.min);
        if (s_q.tm.min == 8'h59) begin
          s_d.tm.hr = (s_q.tm.hr == 8'h23) ? 8'h00 : bcd_inc(s_q.tm.hr);
          if (s_q.tm.hr == 8'h23) begin
            s_d.tm.wday = (s_q.tm.wday == 8'h06) ? 8'h00 : s_q.tm.wday + 8'h01;
            if (s_q.tm.day == last_day(s_q.tm.mon, s_q.tm.yr)) begin
              s_d.tm.day = `RTCCA_DAY_RST;
              s_d.tm.mon = (s_q.tm.mon == 8'h12) ? `RTCCA_MON_RST : bcd_inc(s_q.tm.mon);
              if (s_q.tm.mon == 8'h12) begin
                s_d.tm.yr = (s_q.tm.yr == 8'h99) ? 8'h00 : bcd_inc(s_q.tm.yr);
              end
            end else begin
              s_d.tm.day = bcd_inc(s_q.tm.day);
            end
          end
        end
      end
    end
    // alarm event
    s_d.evt = s_q.armed & hit;
    if (s_d.evt) begin
      if (s_q.rpt != 8'h00 || s_q.chime) begin
        s_d.rpt = s_q.rpt - 8'h01;
      end
      if (s_q.rpt == 8'h00 && !s_q.chime) begin
        s_d.armed = 1'b0;
      end
    end
    // apb handshake: setup, one wait cycle, then ready
    case (s_q.apb)
      RTCCA_IDLE: begin
        if (i_psel && i_penable) begin
          s_d.apb = RTCCA_ACC;
        end
      end
      RTCCA_ACC: begin
        s_d.apb = RTCCA_DONE;
        s_d.slverr = ~mapped;
        s_d.rdata = 32'h0000_0000;
        if (!i_pwrite) begin
          if (a_cfg) begin
            s_d.rdata[15:0] = {s_q.cfg.en, 1'b0, s_q.cfg.unlock, sync_now, half_now,
                               s_q.cfg.oe, s_q.cfg.ptr, s_q.cfg.cal};
          end
          if (a_pad) begin
            s_d.rdata[`RTCCA_B_PINSEL] = s_q.pin_sel;
          end
          if (a_alc) begin
            s_d.rdata[15:0] = {s_q.armed, s_q.chime, s_q.ival, s_q.aptr, s_q.rpt};
          end
          if (a_val) begin
            s_d.rdata[15:0] = val_rd;
          end
          if (a_alm) begin
            s_d.rdata[15:0] = alm_rd;
          end
        end
      end
      RTCCA_DONE: begin
        s_d.apb = RTCCA_IDLE;
        s_d.slverr = 1'b0;
      end
      default: s_d.apb = RTCCA_IDLE;
    endcase
    // completion effects
    if (done) begin
      s_d.key = RTCCA_KEY_NONE;
      if (wr && a_key && i_pstrb[0]) begin
        if (i_pwdata[7:0] == `RTCCA_KEY1) begin
          s_d.key = RTCCA_KEY_55;
        end else if (i_pwdata[7:0] == `RTCCA_KEY2 && s_q.key == RTCCA_KEY_55) begin
          s_d.key = RTCCA_KEY_OK;
        end
      end
      if (wr && a_cfg) begin
        if (i_pstrb[0]) begin
          s_d.cfg.cal = i_pwdata[7:0];
        end
        if (i_pstrb[1]) begin
          s_d.cfg.oe = i_pwdata[`RTCCA_B_OE];
          s_d.cfg.ptr = i_pwdata[9:8];
          // set only straight after the key pair, clear at any time
          s_d.cfg.unlock = i_pwdata[`RTCCA_B_UNLOCK] & (s_q.cfg.unlock | (s_q.key == RTCCA_KEY_OK));
          if (s_q.cfg.unlock) begin
            s_d.cfg.en = i_pwdata[`RTCCA_B_EN];
          end
        end
      end
      if (wr && a_pad && i_pstrb[0]) begin
        s_d.pin_sel = i_pwdata[`RTCCA_B_PINSEL];
      end
      if (wr && a_alc) begin
        if (i_pstrb[0]) begin
          s_d.rpt = i_pwdata[7:0];
        end
        if (i_pstrb[1]) begin
          {s_d.armed, s_d.chime, s_d.ival, s_d.aptr} = i_pwdata[15:8];
        end
      end
      if (wr && a_val && s_q.cfg.unlock) begin
        case (s_q.cfg.ptr)
          2'b00: begin
            if (i_pstrb[0]) begin
              s_d.tm.sec = i_pwdata[7:0] & `RTCCA_M_SEC;
              s_d.cnt = 17'h00000;
            end
            if (i_pstrb[1]) begin
              s_d.tm.min = i_pwdata[15:8] & `RTCCA_M_SEC;
            end
          end
          2'b01: begin
            if (i_pstrb[0]) begin
              s_d.tm.hr = i_pwdata[7:0] & `RTCCA_M_HR;
            end
            if (i_pstrb[1]) begin
              s_d.tm.wday = i_pwdata[15:8] & `RTCCA_M_WD;
            end
          end
          2'b10: begin
            if (i_pstrb[0]) begin
              s_d.tm.day = i_pwdata[7:0] & `RTCCA_M_HR;
            end
            if (i_pstrb[1]) begin
              s_d.tm.mon = i_pwdata[15:8] & `RTCCA_M_MON;
            end
          end
          default: begin
            if (i_pstrb[0]) begin
              s_d.tm.yr = i_pwdata[7:0];
            end
          end
        endcase
      end
      if (wr && a_alm) begin
        case (s_q.aptr)
          2'b00: begin
            if (i_pstrb[0]) begin
              s_d.al.sec = i_pwdata[7:0] & `RTCCA_M_SEC;
            end
            if (i_pstrb[1]) begin
              s_d.al.min = i_pwdata[15:8] & `RTCCA_M_SEC;
            end
          end
          2'b01: begin
            if (i_pstrb[0]) begin
              s_d.al.hr = i_pwdata[7:0] & `RTCCA_M_HR;
            end
            if (i_pstrb[1]) begin
              s_d.al.wday = i_pwdata[15:8] & `RTCCA_M_WD;
            end
          end
          2'b10: begin
            if (i_pstrb[0]) begin
              s_d.al.day = i_pwdata[7:0] & `RTCCA_M_HR;
            end
            if (i_pstrb[1]) begin
              s_d.al.mon = i_pwdata[15:8] & `RTCCA_M_MON;
            end
          end
          default: begin
          end
        endcase
      end
      // pointers step after the access, so the access used the old pair
      if (a_val && rd_eff && s_q.cfg.ptr != 2'b00 && !(wr && a_cfg)) begin
        s_d.cfg.ptr = s_q.cfg.ptr - 2'b01;
      end
      if (a_alm && rd_eff && s_q.aptr != 2'b00) begin
        s_d.aptr = s_q.aptr - 2'b01;
      end
    end
    // output pin
    s_d.pin = s_q.pin_sel ? ~half_now : s_d.evt;
    s_d.pin_oe_b = ~s_q.cfg.oe;
  end

  // =========================================================
  // state register
  localparam rtcca_st_t ST_RST = '{
    apb: RTCCA_IDLE,
    key: RTCCA_KEY_NONE,
    tm: '{day: `RTCCA_DAY_RST, mon: `RTCCA_MON_RST, default: 8'h00},
    al: '{day: `RTCCA_DAY_RST, mon: `RTCCA_MON_RST, default: 8'h00},
    pin_oe_b: 1'b1,
    default: '0
  };
  always_ff @(posedge i_clk) begin
    if (!i_por_b) begin
      s_q <= ST_RST;
    end else if (!i_rst_b) begin
      s_q <= ST_RST;
      s_q.cfg <= s_q.cfg;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    o_prdata = s_q.rdata;
    o_pready = s_q.apb[1];
    o_pslverr = s_q.slverr;
    o_rtc_pin = s_q.pin;
    o_rtc_pin_oe_b = s_q.pin_oe_b;
    o_alarm_evt = s_q.evt;
  end

  // =========================================================
  // checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b || !i_por_b);

  sequence apb_setup_s;
    i_psel && i_penable && s_q.apb == RTCCA_IDLE;
  endsequence
  sequence apb_answer_s;
    !o_pready ##1 o_pready;
  endsequence

  AST_APB_WAIT: assert property (apb_setup_s |=> apb_answer_s)
    else $error("apb ready not on second access cycle");
  AST_WR_LOCK: assert property (wr && a_val && !s_q.cfg.unlock
    && !sec_tick |=> $stable(s_q.tm))
    else $error("locked value write took effect");
  AST_EN_LOCK: assert property (wr && a_cfg && !s_q.cfg.unlock |=> $stable(s_q.cfg.en))
    else $error("enable changed while locked");
  AST_SYNC_BEFORE_CARRY: assert property (sec_tick |-> sync_now && $past(sync_now))
    else $error("carry without rollover flag");
  AST_HALF_CLR: assert property (wr && a_val && s_q.cfg.unlock && s_q.cfg.ptr == 2'b00
    && i_pstrb[0] |=> !half_now)
    else $error("half flag not cleared");
  AST_PIN_OFF: assert property (!s_q.cfg.oe |=> o_rtc_pin_oe_b)
    else $error("pin driven while disabled");
  AST_PTR_DEC: assert property (done && a_val && rd_eff && !(wr && a_cfg)
    && s_q.cfg.ptr != 2'b00 |=> s_q.cfg.ptr == $past(s_q.cfg.ptr) - 2'b01)
    else $error("pointer did not step down");
  AST_DISARM: assert property (s_q.armed && hit && s_q.rpt == 8'h00 && !s_q.chime
    && !(wr && a_alc) |=> !s_q.armed)
    else $error("alarm stayed armed");
  AST_RPT_WRAP: assert property (s_q.armed && hit && s_q.rpt == 8'h00 && s_q.chime
    && !(wr && a_alc) |=> s_q.rpt == 8'hFF)
    else $error("repeat count did not wrap");
  AST_ALARM_PIN: assert property (s_q.cfg.oe && !s_q.pin_sel ##1 s_q.evt
    |-> !o_rtc_pin_oe_b && o_rtc_pin)
    else $error("alarm pulse missing on pin");
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcca_params.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
  // ==========================================
  // signals
  localparam int unsigned XTAL = 64;
  localparam int SEC = XTAL * 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic xtal = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin, pin_oe_b, evt, ev, pin_q;
  logic [31:0] rv;
  logic [7:0] yr, tr;
  int error_cnt = 0;
  int checks_done = 0;
  int evt_cnt = 0;
  int pin_cnt = 0;
  int e0, p0, sh, sy;
  longint cyc = 0;
  longint t_evt [3];
  int unsigned r;
  always #5 clk = ~clk;
  // crystal sped up so a second is 20 clocks per count
  always #100 xtal = ~xtal;
  rtcca_top #(.XTAL_HZ(XTAL)) uut (
    .i_clk(clk), .i_rst_b(rst_b), .i_por_b(por_b), .i_xtal(xtal), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_rtc_pin(pin), .o_rtc_pin_oe_b(pin_oe_b), .o_alarm_evt(evt)
  );
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pin_q <= pin;
    if (evt === 1'b1) begin
      evt_cnt <= evt_cnt + 1;
      t_evt[0] <= t_evt[1];
      t_evt[1] <= t_evt[2];
      t_evt[2] <= cyc;
    end
    if (pin === 1'b1 && pin_q !== 1'b1) begin
      pin_cnt <= pin_cnt + 1;
    end
  end
  // ==========================================
  // tasks
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      give_verdict();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic unlock(input logic [15:0] v);
    apb(1'b1, `RTCCA_OFS_KEY, {24'h00_0000, `RTCCA_KEY1}, 4'h1);
    apb(1'b1, `RTCCA_OFS_KEY, {24'h00_0000, `RTCCA_KEY2}, 4'h1);
    apb(1'b1, `RTCCA_OFS_CFG, {16'h0000, v | 16'h2000}, 4'h3);
  endtask
  task automatic wait_evt();
    int n;
    int e;
    n = 0;
    e = evt_cnt;
    while (evt_cnt == e && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (evt_cnt == e) begin
      error_cnt++;
      $display("[FAIL] alarm event expected 1 seen 0");
      give_verdict();
    end
  endtask
  // ==========================================
  // sequence
  initial begin
    r = $urandom(32'ha16053f0);
    repeat (5) @(posedge clk);
    por_b <= 1'b1;
    rst_b <= 1'b1;
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("cfg_reset", 16'h0000, rv[15:0] & 16'hA7FF);
    apb(1'b0, `RTCCA_OFS_PAD, 32'h0000_0000, 4'h0);
    `CHK("pad_reset", 32'h0000_0000, rv);
    apb(1'b0, `RTCCA_OFS_ALCFG, 32'h0000_0000, 4'h0);
    `CHK("alcfg_reset", 32'h0000_0000, rv);
    apb(1'b0, 12'h0FC, 32'h0000_0000, 4'h0);
    `CHK("unmapped_err", 1'b1, ev);
    // locked: enable and value writes must not land
    apb(1'b1, `RTCCA_OFS_CFG, 32'h0000_8000, 4'h3);
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("en_locked", 1'b0, rv[15]);
    apb(1'b1, `RTCCA_OFS_VAL, 32'h0000_1234, 4'h3);
    apb(1'b0, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h0);
    `CHK("val_locked", 32'h0000_0000, rv);
    // key sequence broken by a read must not unlock
    apb(1'b1, `RTCCA_OFS_KEY, {24'h00_0000, `RTCCA_KEY1}, 4'h1);
    apb(1'b1, `RTCCA_OFS_KEY, {24'h00_0000, `RTCCA_KEY2}, 4'h1);
    apb(1'b0, `RTCCA_OFS_PAD, 32'h0000_0000, 4'h0);
    apb(1'b1, `RTCCA_OFS_CFG, 32'h0000_2000, 4'h3);
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("unlock_late", 1'b0, rv[13]);
    unlock(16'h0300);
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("unlock_ptr", 3'b111, {rv[13], rv[9:8]});
    // ==========================================
    // window pointer walk
    yr = 8'(($urandom_range(9, 1) << 4) | $urandom_range(9));
    apb(1'b1, `RTCCA_OFS_VAL, {24'h00_0000, yr}, 4'h3);
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("ptr_after_wr", 2'b10, rv[9:8]);
    apb(1'b0, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h0);
    `CHK("mon_day", 32'h0000_0101, rv);
    apb(1'b0, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h0);
    `CHK("wday_hr", 32'h0000_0000, rv);
    apb(1'b0, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h0);
    `CHK("min_sec", 32'h0000_0000, rv);
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("ptr_sat", 2'b00, rv[9:8]);
    apb(1'b1, `RTCCA_OFS_CFG, 32'h0000_0300, 4'h3);
    apb(1'b1, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h1);
    apb(1'b0, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h0);
    `CHK("year", {24'h00_0000, yr}, rv);
    // ==========================================
    // warm reset keeps config and trim
    tr = 8'($urandom);
    apb(1'b1, `RTCCA_OFS_CFG, {16'h0000, 8'h06, tr}, 4'h3);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("cfg_keep", {8'h06, tr}, rv[15:0] & 16'hA7FF);
    `CHK("oe_on", 1'b0, pin_oe_b);
    apb(1'b1, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h3);
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("oe_off", 1'b1, pin_oe_b);
    // ==========================================
    // running: half flag and rollover flag
    unlock(16'h0400);
    unlock(16'h8400);
    apb(1'b1, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h1);
    apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
    `CHK("en_set", 1'b1, rv[15]);
    `CHK("half_clear", 2'b00, rv[12:11]);
    sh = 0;
    sy = 0;
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, `RTCCA_OFS_CFG, 32'h0000_0000, 4'h0);
      if (rv[11] === 1'b1) sh = 1;
      if (rv[12] === 1'b1) sy = 1;
    end
    `CHK("half_seen", 1, sh);
    `CHK("sync_seen", 1, sy);
    // ==========================================
    // alarm repeat, chime and intervals
    e0 = evt_cnt;
    p0 = pin_cnt;
    apb(1'b1, `RTCCA_OFS_ALCFG, 32'h0000_8402, 4'h3);
    repeat (5 * SEC) @(posedge clk);
    `CHK("evt_rpt", 3, evt_cnt - e0);
    `CHK("pin_alarm", 3, pin_cnt - p0);
    apb(1'b0, `RTCCA_OFS_ALCFG, 32'h0000_0000, 4'h0);
    `CHK("alcfg_done", 32'h0000_0400, rv);
    apb(1'b1, `RTCCA_OFS_ALCFG, 32'h0000_C400, 4'h3);
    wait_evt();
    apb(1'b0, `RTCCA_OFS_ALCFG, 32'h0000_0000, 4'h0);
    `CHK("chime_wrap", 32'h0000_C4FF, rv);
    apb(1'b1, `RTCCA_OFS_ALCFG, 32'h0000_0200, 4'h3);
    apb(1'b1, `RTCCA_OFS_ALM, 32'h0000_1225, 4'h3);
    apb(1'b0, `RTCCA_OFS_ALCFG, 32'h0000_0000, 4'h0);
    `CHK("aptr_step", 2'b01, rv[9:8]);
    apb(1'b1, `RTCCA_OFS_ALCFG, 32'h0000_0200, 4'h3);
    apb(1'b0, `RTCCA_OFS_ALM, 32'h0000_0000, 4'h0);
    `CHK("alm_mon_day", 32'h0000_1225, rv);
    for (int c = 0; c < 10; c++) begin
      apb(1'b1, `RTCCA_OFS_ALCFG, {16'h0000, 2'b11, 4'(c), 10'h000}, 4'h3);
      if (c < 2) begin
        // skip the edges whose event still came from the previous setting
        repeat (2) @(posedge clk);
        e0 = evt_cnt;
        repeat (2 * SEC) @(posedge clk);
        `CHK("ival_rate", (2 - c) * 2, evt_cnt - e0);
      end
      apb(1'b0, `RTCCA_OFS_ALCFG, 32'h0000_0000, 4'h0);
      `CHK("ival_field", 4'(c), rv[13:10]);
    end
    // ==========================================
    // trim at minute rollover
    unlock(16'h8403);
    apb(1'b1, `RTCCA_OFS_VAL, 32'h0000_0058, 4'h3);
    apb(1'b1, `RTCCA_OFS_ALCFG, 32'h0000_C400, 4'h3);
    wait_evt();
    wait_evt();
    wait_evt();
    apb(1'b0, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h0);
    `CHK("time_adv", 32'h0000_0101, rv);
    apb(1'b0, `RTCCA_OFS_VAL, 32'h0000_0000, 4'h0);
    `CHK("time_twice", 32'h0000_0101, rv);
    `CHK("gap_norm", longint'(SEC), t_evt[1] - t_evt[0]);
    `CHK("gap_trim", longint'((XTAL - 12) * 20), t_evt[2] - t_evt[1]);
    // ==========================================
    // seconds clock on the pin
    apb(1'b1, `RTCCA_OFS_ALCFG, 32'h0000_0000, 4'h3);
    apb(1'b1, `RTCCA_OFS_PAD, 32'h0000_0002, 4'h1);
    // the source switch itself may raise the pin once; let it pass
    repeat (4) @(posedge clk);
    p0 = pin_cnt;
    repeat (2 * SEC) @(posedge clk);
    `CHK("pin_1hz", 2, pin_cnt - p0);
    `CHK("oe_on_sec", 1'b0, pin_oe_b);
    apb(1'b1, `RTCCA_OFS_CFG, 32'h0000_8000, 4'h3);
    repeat (4) @(posedge clk);
    `CHK("oe_off_sec", 1'b1, pin_oe_b);
    give_verdict();
  end
endmodule
`default_nettype wire
